// *** src/sfr_slice_pkg.sv ***
// constants, field layouts and carrier types for the bank-0 upper special-register slice
package sfr_slice_pkg;
  localparam int ADDR_W = 9;
  localparam int DATA_W = 8;

  // offsets inside a bank (low seven address bits) and the bank field
  localparam logic [1:0] BANK_ZERO     = 2'h0;
  localparam logic [1:0] BANK_ONE      = 2'h1;
  localparam logic [6:0] OFF_PC_LATCH  = 7'h0A;
  localparam logic [6:0] OFF_IRQ_A     = 7'h0C;
  localparam logic [6:0] OFF_IRQ_B     = 7'h0D;
  localparam logic [6:0] OFF_T1_LOW    = 7'h0E;
  localparam logic [6:0] OFF_T1_HIGH   = 7'h0F;
  localparam logic [6:0] OFF_T1_CTRL   = 7'h10;
  localparam logic [6:0] OFF_T2_COUNT  = 7'h11;
  localparam logic [6:0] OFF_T2_CTRL   = 7'h12;
  localparam logic [6:0] OFF_SSP_BUF   = 7'h13;
  localparam logic [6:0] OFF_SSP_CTRL  = 7'h14;
  localparam logic [6:0] OFF_CC1_LOW   = 7'h15;
  localparam logic [6:0] OFF_CC1_HIGH  = 7'h16;
  localparam logic [6:0] OFF_CC1_CTRL  = 7'h17;
  localparam logic [6:0] OFF_UART_RXS  = 7'h18;
  localparam logic [6:0] OFF_UART_TX   = 7'h19;
  localparam logic [6:0] OFF_UART_RX   = 7'h1A;
  localparam logic [6:0] OFF_CC2_LOW   = 7'h1B;
  localparam logic [6:0] OFF_CC2_HIGH  = 7'h1C;
  localparam logic [6:0] OFF_CC2_CTRL  = 7'h1D;
  localparam logic [6:0] OFF_ADC_RES   = 7'h1E;
  localparam logic [6:0] OFF_ADC_CTRL  = 7'h1F;
  localparam logic [6:0] OFF_PORT_E_DIR = 7'h09;
  localparam logic [6:0] OFF_SSP_ADDR  = 7'h13;

  // implemented-bit masks; clear bits read zero and ignore writes, except the receive-status pair, which splits software from receiver bits
  localparam logic [7:0] MASK_FULL     = 8'hFF;
  localparam logic [7:0] MASK_PC_LATCH = 8'h1F;
  localparam logic [7:0] MASK_IRQ_B    = 8'h01;
  localparam logic [7:0] MASK_T1_CTRL  = 8'hFD;
  localparam logic [7:0] MASK_T2_CTRL  = 8'h7F;
  localparam logic [7:0] MASK_CC_CTRL  = 8'h3F;
  localparam logic [7:0] MASK_ADC_CTRL = 8'h3F;
  localparam logic [7:0] MASK_RXS_SW   = 8'hF8;
  localparam logic [7:0] MASK_RXS_HW   = 8'h07;
  localparam logic [3:0] MASK_DIR_FULL = 4'hF;
  localparam logic [3:0] MASK_DIR_SMALL = 4'h8;

  // field positions
  localparam int T1_ON_BIT     = 0;
  localparam int T2_ON_BIT     = 2;
  localparam int ADC_GO_BIT    = 1;
  localparam int IRQ_T1_BIT    = 0;
  localparam int IRQ_T2_BIT    = 1;
  localparam int IRQ_ADC_BIT   = 6;
  localparam int IRQ_RX_BIT    = 5;
  localparam int IRQ_SSP_BIT   = 3;
  localparam int DIR_INPUT_BIT = 3;
  localparam logic [3:0] SSP_MODE_MASKED = 4'h9;

  // values after reset
  localparam logic [7:0] RST_ZERO      = 8'h00;
  localparam logic [7:0] RST_SSP_MASK  = 8'hFF;
  localparam logic [3:0] RST_PORT_E_DIR = 4'hF;
  localparam logic [4:0] RST_PC_LATCH  = 5'h00;

  typedef struct packed {
    logic [7:0]  t1_ctrl;
    logic [7:0]  t2_ctrl;
    logic [7:0]  ssp_ctrl;
    logic [7:0]  ssp_addr;
    logic [7:0]  ssp_mask;
    logic [7:0]  cc1_ctrl;
    logic [7:0]  cc2_ctrl;
    logic [15:0] cc1_value;
    logic [15:0] cc2_value;
    logic [7:0]  uart_rx_ctrl;
    logic [7:0]  uart_tx_data;
    logic [7:0]  adc_ctrl;
    logic [3:0]  port_e_dir;
  } ctrl_s;

  typedef struct packed {
    logic [7:0] irq_a_set;
    logic       irq_b_set;
    logic       t1_tick;
    logic       t2_tick;
    logic       ssp_rx_valid;
    logic [7:0] ssp_rx_data;
    logic       uart_rx_valid;
    logic [7:0] uart_rx_data;
    logic [2:0] uart_rx_status;
    logic       adc_done;
    logic [7:0] adc_data;
    logic       cc1_capture;
    logic       cc2_capture;
  } periph_s;
endpackage : sfr_slice_pkg

// *** src/sfr_bank0_upper_slice.sv ***
// bank-0 upper special-register slice with common latch and shared serial address
//
// What this block does
// - unimplemented locations and bits read zero; writes to them do nothing
// - pc upper latch holds bits 12:8, copied into counter upper on load
// - common registers decode at the same offset in every bank
// - bits missing on small-package variants read zero; ctrl_o carries them as ones from reset until the first direction write
// - shared serial address: mask only when serial mode is 1001
// - input-only pin direction bit always reads one, writes ignored
// - reset notation: unknown, unchanged, conditional, unimplemented, reserved
// - sixteen-bit timer one count seen as low byte 0Eh, high 0Fh
//
// The strobed register port was decided locally.
`timescale 1ns/100ps
module sfr_bank0_upper_slice
  import sfr_slice_pkg::*;
#(
  parameter bit LARGE_PACKAGE = 1'b1
) (
  input  wire logic              ref_clk_i,
  input  wire logic              srst_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  input  wire logic              pc_load_i,
  input  wire periph_s           periph_i,
  output logic [DATA_W-1:0]      rdata_o,
  output logic [4:0]             pc_upper_o,
  output ctrl_s                  ctrl_o,
  output logic                   tx_load_o,
  output logic                   ssp_tx_load_o
);

  // bank-0 hit; used for both write and read decode
  function automatic logic bank0_hit(input logic [ADDR_W-1:0] a, input logic [6:0] off);
    bank0_hit = (a[8:7] == BANK_ZERO) && (a[6:0] == off);
  endfunction : bank0_hit

  function automatic logic bank1_hit(input logic [ADDR_W-1:0] a, input logic [6:0] off);
    bank1_hit = (a[8:7] == BANK_ONE) && (a[6:0] == off);
  endfunction : bank1_hit

  logic [7:0]  irq_a_r;
  logic [7:0]  irq_b_r;
  logic [15:0] t1_cnt_r;
  logic [7:0]  t2_cnt_r;
  logic [7:0]  ssp_buf_r;
  logic [7:0]  uart_rx_r;
  logic [7:0]  adc_res_r;
  logic [4:0]  pc_latch_r;
  logic [4:0]  pc_upper_r;
  logic [7:0]  rdata_r;
  logic        tx_load_r;
  logic        ssp_tx_load_r;
  ctrl_s       ctrl_r;

  logic [7:0]  irq_a_nxt;
  logic [7:0]  irq_b_nxt;
  logic [15:0] t1_cnt_nxt;
  logic [7:0]  t2_cnt_nxt;
  logic [7:0]  ssp_buf_nxt;
  logic [7:0]  uart_rx_nxt;
  logic [7:0]  adc_res_nxt;
  logic [4:0]  pc_latch_nxt;
  logic [7:0]  rdata_nxt;
  ctrl_s       ctrl_nxt;

  // write decode
  // latch decoded in any bank
  wire w_pc_latch = wr_i && (addr_i[6:0] == OFF_PC_LATCH);
  wire w_irq_a    = wr_i && bank0_hit(addr_i, OFF_IRQ_A);
  wire w_irq_b    = wr_i && bank0_hit(addr_i, OFF_IRQ_B);
  wire w_t1_low   = wr_i && bank0_hit(addr_i, OFF_T1_LOW);
  wire w_t1_high  = wr_i && bank0_hit(addr_i, OFF_T1_HIGH);
  wire w_t1_ctrl  = wr_i && bank0_hit(addr_i, OFF_T1_CTRL);
  wire w_t2_count = wr_i && bank0_hit(addr_i, OFF_T2_COUNT);
  wire w_t2_ctrl  = wr_i && bank0_hit(addr_i, OFF_T2_CTRL);
  wire w_ssp_buf  = wr_i && bank0_hit(addr_i, OFF_SSP_BUF);
  wire w_ssp_ctrl = wr_i && bank0_hit(addr_i, OFF_SSP_CTRL);
  wire w_cc1_low  = wr_i && bank0_hit(addr_i, OFF_CC1_LOW);
  wire w_cc1_high = wr_i && bank0_hit(addr_i, OFF_CC1_HIGH);
  wire w_cc1_ctrl = wr_i && bank0_hit(addr_i, OFF_CC1_CTRL);
  wire w_uart_rxs = wr_i && bank0_hit(addr_i, OFF_UART_RXS);
  wire w_uart_tx  = wr_i && bank0_hit(addr_i, OFF_UART_TX);
  wire w_cc2_low  = wr_i && bank0_hit(addr_i, OFF_CC2_LOW);
  wire w_cc2_high = wr_i && bank0_hit(addr_i, OFF_CC2_HIGH);
  wire w_cc2_ctrl = wr_i && bank0_hit(addr_i, OFF_CC2_CTRL);
  wire w_adc_ctrl = wr_i && bank0_hit(addr_i, OFF_ADC_CTRL);
  wire w_port_dir = wr_i && bank1_hit(addr_i, OFF_PORT_E_DIR);

  // mode field picks mask or address
  wire ssp_masked   = (ctrl_r.ssp_ctrl[3:0] == SSP_MODE_MASKED);
  wire w_ssp_shared = wr_i && bank1_hit(addr_i, OFF_SSP_ADDR);
  wire w_ssp_mask   = w_ssp_shared && ssp_masked;
  wire w_ssp_addr   = w_ssp_shared && !ssp_masked;

  // small package drops low direction bits
  wire [3:0] dir_mask = LARGE_PACKAGE ? MASK_DIR_FULL : MASK_DIR_SMALL;

  // timer one increment, overflow raises its flag
  wire        t1_run   = periph_i.t1_tick && ctrl_r.t1_ctrl[T1_ON_BIT];
  wire [16:0] t1_sum   = {1'b0, t1_cnt_r} + 17'h00001;
  wire        t1_wrap  = t1_run && t1_sum[16];
  wire        t2_run   = periph_i.t2_tick && ctrl_r.t2_ctrl[T2_ON_BIT];
  wire        t2_wrap  = t2_run && (t2_cnt_r == 8'hFF);

  wire [7:0] hw_irq_a = periph_i.irq_a_set
                      | ({7'h00, t1_wrap} << IRQ_T1_BIT)
                      | ({7'h00, t2_wrap} << IRQ_T2_BIT)
                      | ({7'h00, periph_i.adc_done} << IRQ_ADC_BIT)
                      | ({7'h00, periph_i.uart_rx_valid} << IRQ_RX_BIT)
                      | ({7'h00, periph_i.ssp_rx_valid} << IRQ_SSP_BIT);

  always_comb begin
    // hardware set is ored after the software write so a same-cycle event survives
    irq_a_nxt = (w_irq_a ? wdata_i : irq_a_r) | hw_irq_a;
    irq_b_nxt = ((w_irq_b ? wdata_i : irq_b_r) | {7'h00, periph_i.irq_b_set}) & MASK_IRQ_B;
  end

  // byte writes load the count halves
  always_comb begin
    t1_cnt_nxt = t1_run ? t1_sum[15:0] : t1_cnt_r;
    if (w_t1_low) begin
      t1_cnt_nxt[7:0] = wdata_i;
    end
    if (w_t1_high) begin
      t1_cnt_nxt[15:8] = wdata_i;
    end
  end

  always_comb begin
    if (w_t2_count) begin
      t2_cnt_nxt = wdata_i;
    end else if (t2_run) begin
      t2_cnt_nxt = t2_cnt_r + 8'h01;
    end else begin
      t2_cnt_nxt = t2_cnt_r;
    end
  end

  // received serial byte overrides a same-cycle software write to the buffer
  always_comb begin
    if (periph_i.ssp_rx_valid) begin
      ssp_buf_nxt = periph_i.ssp_rx_data;
    end else if (w_ssp_buf) begin
      ssp_buf_nxt = wdata_i;
    end else begin
      ssp_buf_nxt = ssp_buf_r;
    end
  end

  always_comb begin
    uart_rx_nxt = periph_i.uart_rx_valid ? periph_i.uart_rx_data : uart_rx_r;
    adc_res_nxt = periph_i.adc_done ? periph_i.adc_data : adc_res_r;
  end

  // only the low five bits of the latch exist
  always_comb begin
    pc_latch_nxt = w_pc_latch ? wdata_i[4:0] : pc_latch_r;
  end

  always_comb begin
    ctrl_nxt = ctrl_r;
    // control registers store on decoded write
    if (w_t1_ctrl) begin
      ctrl_nxt.t1_ctrl = wdata_i & MASK_T1_CTRL;
    end
    if (w_t2_ctrl) begin
      ctrl_nxt.t2_ctrl = wdata_i & MASK_T2_CTRL;
    end
    if (w_ssp_ctrl) begin
      ctrl_nxt.ssp_ctrl = wdata_i;
    end
    if (w_ssp_addr) begin
      ctrl_nxt.ssp_addr = wdata_i;
    end
    if (w_ssp_mask) begin
      ctrl_nxt.ssp_mask = wdata_i;
    end
    if (w_cc1_ctrl) begin
      ctrl_nxt.cc1_ctrl = wdata_i & MASK_CC_CTRL;
    end
    if (w_cc2_ctrl) begin
      ctrl_nxt.cc2_ctrl = wdata_i & MASK_CC_CTRL;
    end
    // capture takes the whole timer count; a software byte write wins
    if (periph_i.cc1_capture) begin
      ctrl_nxt.cc1_value = t1_cnt_r;
    end
    if (w_cc1_low) begin
      ctrl_nxt.cc1_value[7:0] = wdata_i;
    end
    if (w_cc1_high) begin
      ctrl_nxt.cc1_value[15:8] = wdata_i;
    end
    if (periph_i.cc2_capture) begin
      ctrl_nxt.cc2_value = t1_cnt_r;
    end
    if (w_cc2_low) begin
      ctrl_nxt.cc2_value[7:0] = wdata_i;
    end
    if (w_cc2_high) begin
      ctrl_nxt.cc2_value[15:8] = wdata_i;
    end
    // low status bits belong to the receiver, not to software
    if (w_uart_rxs) begin
      ctrl_nxt.uart_rx_ctrl[7:3] = wdata_i[7:3];
    end
    if (periph_i.uart_rx_valid) begin
      ctrl_nxt.uart_rx_ctrl[2:0] = periph_i.uart_rx_status;
    end
    if (w_uart_tx) begin
      ctrl_nxt.uart_tx_data = wdata_i;
    end
    // conversion end drops go unless software rewrites it in the same cycle
    if (periph_i.adc_done) begin
      ctrl_nxt.adc_ctrl[ADC_GO_BIT] = 1'b0;
    end
    if (w_adc_ctrl) begin
      ctrl_nxt.adc_ctrl = wdata_i & MASK_ADC_CTRL;
    end
    if (w_port_dir) begin
      ctrl_nxt.port_e_dir = (wdata_i[3:0] & dir_mask) | MASK_DIR_SMALL;
    end
  end

  // read selection
  always_comb begin
    rdata_nxt = RST_ZERO;
    if (addr_i[6:0] == OFF_PC_LATCH) begin
      rdata_nxt = {3'h0, pc_latch_r};
    end else if (bank0_hit(addr_i, OFF_IRQ_A)) begin
      rdata_nxt = irq_a_r;
    end else if (bank0_hit(addr_i, OFF_IRQ_B)) begin
      rdata_nxt = irq_b_r & MASK_IRQ_B;
    end else if (bank0_hit(addr_i, OFF_T1_LOW)) begin
      rdata_nxt = t1_cnt_r[7:0];
    end else if (bank0_hit(addr_i, OFF_T1_HIGH)) begin
      rdata_nxt = t1_cnt_r[15:8];
    end else if (bank0_hit(addr_i, OFF_T1_CTRL)) begin
      rdata_nxt = ctrl_r.t1_ctrl & MASK_T1_CTRL;
    end else if (bank0_hit(addr_i, OFF_T2_COUNT)) begin
      rdata_nxt = t2_cnt_r;
    end else if (bank0_hit(addr_i, OFF_T2_CTRL)) begin
      rdata_nxt = ctrl_r.t2_ctrl & MASK_T2_CTRL;
    end else if (bank0_hit(addr_i, OFF_SSP_BUF)) begin
      rdata_nxt = ssp_buf_r;
    end else if (bank0_hit(addr_i, OFF_SSP_CTRL)) begin
      rdata_nxt = ctrl_r.ssp_ctrl;
    end else if (bank0_hit(addr_i, OFF_CC1_LOW)) begin
      rdata_nxt = ctrl_r.cc1_value[7:0];
    end else if (bank0_hit(addr_i, OFF_CC1_HIGH)) begin
      rdata_nxt = ctrl_r.cc1_value[15:8];
    end else if (bank0_hit(addr_i, OFF_CC1_CTRL)) begin
      rdata_nxt = ctrl_r.cc1_ctrl & MASK_CC_CTRL;
    end else if (bank0_hit(addr_i, OFF_UART_RXS)) begin
      rdata_nxt = ctrl_r.uart_rx_ctrl;
    end else if (bank0_hit(addr_i, OFF_UART_TX)) begin
      rdata_nxt = ctrl_r.uart_tx_data;
    end else if (bank0_hit(addr_i, OFF_UART_RX)) begin
      rdata_nxt = uart_rx_r;
    end else if (bank0_hit(addr_i, OFF_CC2_LOW)) begin
      rdata_nxt = ctrl_r.cc2_value[7:0];
    end else if (bank0_hit(addr_i, OFF_CC2_HIGH)) begin
      rdata_nxt = ctrl_r.cc2_value[15:8];
    end else if (bank0_hit(addr_i, OFF_CC2_CTRL)) begin
      rdata_nxt = ctrl_r.cc2_ctrl & MASK_CC_CTRL;
    end else if (bank0_hit(addr_i, OFF_ADC_RES)) begin
      rdata_nxt = adc_res_r;
    end else if (bank0_hit(addr_i, OFF_ADC_CTRL)) begin
      rdata_nxt = ctrl_r.adc_ctrl & MASK_ADC_CTRL;
    end else if (bank1_hit(addr_i, OFF_PORT_E_DIR)) begin
      rdata_nxt = {4'h0, (ctrl_r.port_e_dir & dir_mask) | MASK_DIR_SMALL};
    end else if (bank1_hit(addr_i, OFF_SSP_ADDR)) begin
      rdata_nxt = ssp_masked ? ctrl_r.ssp_mask : ctrl_r.ssp_addr;
    end
  end

  // unknown-at-reset registers still get zero so control is defined
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      irq_a_r   <= RST_ZERO;
      irq_b_r   <= RST_ZERO;
      t1_cnt_r  <= {RST_ZERO, RST_ZERO};
      t2_cnt_r  <= RST_ZERO;
      ssp_buf_r <= RST_ZERO;
      uart_rx_r <= RST_ZERO;
      adc_res_r <= RST_ZERO;
    end else begin
      irq_a_r   <= irq_a_nxt;
      irq_b_r   <= irq_b_nxt;
      t1_cnt_r  <= t1_cnt_nxt;
      t2_cnt_r  <= t2_cnt_nxt;
      ssp_buf_r <= ssp_buf_nxt;
      uart_rx_r <= uart_rx_nxt;
      adc_res_r <= adc_res_nxt;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      ctrl_r            <= '0;
      ctrl_r.ssp_mask   <= RST_SSP_MASK;
      ctrl_r.port_e_dir <= RST_PORT_E_DIR;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // counter upper copied from latch on load
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      pc_latch_r <= RST_PC_LATCH;
      pc_upper_r <= RST_PC_LATCH;
    end else begin
      pc_latch_r <= pc_latch_nxt;
      if (pc_load_i) begin
        pc_upper_r <= pc_latch_r;
      end
    end
  end

  // read data registered: valid only the cycle after the strobe
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      rdata_r       <= RST_ZERO;
      tx_load_r     <= 1'b0;
      ssp_tx_load_r <= 1'b0;
    end else begin
      rdata_r       <= rd_i ? rdata_nxt : RST_ZERO;
      tx_load_r     <= w_uart_tx;
      ssp_tx_load_r <= w_ssp_buf;
    end
  end

  assign rdata_o       = rdata_r;
  assign pc_upper_o    = pc_upper_r;
  assign ctrl_o        = ctrl_r;
  assign tx_load_o     = tx_load_r;
  assign ssp_tx_load_o = ssp_tx_load_r;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);

  wire rd_gap = rd_i && (addr_i[8:7] == BANK_ZERO) && (addr_i[6:0] > OFF_PC_LATCH)
              && (addr_i[6:0] < OFF_IRQ_A);

  chk_gap_reads_zero: assert property (
    rd_gap |=> (rdata_o == RST_ZERO))
    else $error("unmapped location read nonzero");

  chk_pc_upper_copy: assert property (
    pc_load_i |=> (pc_upper_o == $past(pc_latch_r)))
    else $error("counter upper not taken from latch");

  chk_latch_any_bank: assert property (
    (wr_i && addr_i[6:0] == OFF_PC_LATCH) ##1 (rd_i && addr_i[6:0] == OFF_PC_LATCH)
    |=> (rdata_o == {3'h0, $past(wdata_i[4:0], 2)}))
    else $error("common latch differs between banks");

  chk_small_pkg_zero: assert property (
    (rd_i && bank1_hit(addr_i, OFF_PORT_E_DIR) && !LARGE_PACKAGE) |=> (rdata_o[2:0] == 3'h0))
    else $error("absent direction bits read nonzero");

  chk_mask_guarded: assert property (
    (w_ssp_shared && !ssp_masked) |=> $stable(ctrl_r.ssp_mask))
    else $error("mask written outside masked mode");

  chk_input_dir_one: assert property (
    (rd_i && bank1_hit(addr_i, OFF_PORT_E_DIR)) |=> rdata_o[DIR_INPUT_BIT])
    else $error("input-only direction bit read low");

  chk_reset_defined: assert property (
    disable iff (1'b0) $past(srst_i) |-> (irq_a_r == RST_ZERO && ctrl_r.ssp_mask == RST_SSP_MASK
                                        && ctrl_r.port_e_dir == RST_PORT_E_DIR))
    else $error("register not at reset value");

  chk_timer_bytes: assert property (
    (rd_i && bank0_hit(addr_i, OFF_T1_HIGH)) |=> (rdata_o == $past(t1_cnt_r[15:8])))
    else $error("timer high byte read wrong");

  chk_ctrl_write: assert property (
    w_t2_ctrl |=> (ctrl_r.t2_ctrl == ($past(wdata_i) & MASK_T2_CTRL)))
    else $error("control write not stored");

  chk_flag_set_wins: assert property (
    (w_irq_a && periph_i.irq_a_set[7] && !wdata_i[7]) |=> irq_a_r[7])
    else $error("flag event lost against clear");

endmodule : sfr_bank0_upper_slice

// *** dv/core_bus_model.sv ***
// processor-core model that masters the register port
`timescale 1ns/100ps
module core_bus_model
  import sfr_slice_pkg::*;
(
  input  wire logic              ref_clk_i,
  input  wire logic [DATA_W-1:0] rdata_i,
  input  wire logic [DATA_W-1:0] rdata_alt_i,
  output logic [ADDR_W-1:0]      addr_o,
  output logic [DATA_W-1:0]      wdata_o,
  output logic                   wr_o,
  output logic                   rd_o
);
  initial begin
    addr_o  = '0;
    wdata_o = '0;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
  end

  // released lines show inverted values so a stale sample cannot pass
  task automatic write_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge ref_clk_i);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge ref_clk_i);
    wr_o    <= 1'b0;
    addr_o  <= ~a;
    wdata_o <= ~d;
  endtask : write_reg

  task automatic read_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d,
                          output logic [DATA_W-1:0] d_alt);
    @(posedge ref_clk_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge ref_clk_i);
    rd_o   <= 1'b0;
    addr_o <= ~a;
    // read data stand only in the cycle after the strobe
    @(posedge ref_clk_i);
    d     = rdata_i;
    d_alt = rdata_alt_i;
  endtask : read_reg

  // write strobe followed at once by a read strobe, no idle cycle between
  task automatic write_then_read(input logic [ADDR_W-1:0] wa, input logic [DATA_W-1:0] wd,
                                 input logic [ADDR_W-1:0] ra, output logic [DATA_W-1:0] d);
    @(posedge ref_clk_i);
    addr_o  <= wa;
    wdata_o <= wd;
    wr_o    <= 1'b1;
    @(posedge ref_clk_i);
    wr_o    <= 1'b0;
    rd_o    <= 1'b1;
    addr_o  <= ra;
    wdata_o <= ~wd;
    @(posedge ref_clk_i);
    rd_o    <= 1'b0;
    addr_o  <= ~ra;
    @(posedge ref_clk_i);
    d = rdata_i;
  endtask : write_then_read
endmodule : core_bus_model

// *** dv/sfr_bank0_upper_slice_tb.sv ***
// self-checking bench for the bank-0 upper special-register slice
`timescale 1ns/100ps
module sfr_bank0_upper_slice_tb
  import sfr_slice_pkg::*;
;
  logic              ref_clk_i = 1'b0;
  logic              srst_i    = 1'b1;
  logic              pc_load   = 1'b0;
  periph_s           periph    = '0;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              wr;
  logic              rd;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] rdata_small;
  logic [4:0]        pc_upper;
  ctrl_s             ctrl;
  logic              tx_load;
  logic              ssp_tx_load;
  int                fail_count      = 0;
  int                samples_checked = 0;

  always #10 ref_clk_i = ~ref_clk_i;

  core_bus_model core (.ref_clk_i(ref_clk_i), .rdata_i(rdata), .rdata_alt_i(rdata_small),
                       .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));

  sfr_bank0_upper_slice #(.LARGE_PACKAGE(1'b1)) dut (
    .ref_clk_i(ref_clk_i), .srst_i(srst_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .pc_load_i(pc_load), .periph_i(periph), .rdata_o(rdata),
    .pc_upper_o(pc_upper), .ctrl_o(ctrl), .tx_load_o(tx_load), .ssp_tx_load_o(ssp_tx_load));

  // reduced-pin variant sharing the same bus
  sfr_bank0_upper_slice #(.LARGE_PACKAGE(1'b0)) dut_small (
    .ref_clk_i(ref_clk_i), .srst_i(srst_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .pc_load_i(pc_load), .periph_i(periph), .rdata_o(rdata_small),
    .pc_upper_o(), .ctrl_o(), .tx_load_o(), .ssp_tx_load_o());

  task automatic wrap_up();
    $display("checked %0d values, %0d mismatches", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up

  task automatic cmp_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask : cmp_byte

  task automatic cmp_bit(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      $display("[ERR] %s expected %b seen %b", what, exp, got);
      fail_count++;
    end
  endtask : cmp_bit

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic [7:0] d_alt;
    core.read_reg(a, d, d_alt);
    cmp_byte($sformatf("read %h", a), exp, d);
  endtask : rd_chk

  task automatic t_reset();
    for (int a = 'h0C; a <= 'h1F; a++) rd_chk(9'(a), 8'h00);
    rd_chk(9'h093, 8'h00);
    rd_chk(9'h089, 8'h0F);
    rd_chk(9'h00A, 8'h00);
    $display("reset test done");
  endtask : t_reset

  task automatic t_masks();
    logic [8:0] adr [11] = '{9'h00D, 9'h010, 9'h012, 9'h017, 9'h01D, 9'h01F, 9'h00A,
                             9'h018, 9'h01A, 9'h01E, 9'h020};
    logic [7:0] msk [11] = '{8'h01, 8'hFD, 8'h7F, 8'h3F, 8'h3F, 8'h3F, 8'h1F,
                             8'hF8, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 11; i++) begin
      core.write_reg(adr[i], 8'hFF);
      rd_chk(adr[i], msk[i]);
    end
    cmp_byte("adc ctrl out", 8'h3F, ctrl.adc_ctrl);
    rd_chk(9'h00B, 8'h00);
    for (int i = 0; i < 8; i++) core.write_reg(adr[i], 8'h00);
    rd_chk(9'h012, 8'h00);
    $display("mask test done");
  endtask : t_masks

  task automatic t_timer();
    core.write_reg(9'h00E, 8'hA5);
    core.write_reg(9'h00F, 8'h3C);
    rd_chk(9'h00E, 8'hA5);
    rd_chk(9'h00F, 8'h3C);
    core.write_reg(9'h00E, 8'hFF);
    core.write_reg(9'h00F, 8'hFF);
    core.write_reg(9'h00C, 8'h00);
    core.write_reg(9'h010, 8'h01);
    @(posedge ref_clk_i) periph.t1_tick <= 1'b1;
    @(posedge ref_clk_i) periph.t1_tick <= 1'b0;
    rd_chk(9'h00E, 8'h00);
    rd_chk(9'h00F, 8'h00);
    rd_chk(9'h00C, 8'h01);
    core.write_reg(9'h010, 8'h00);
    $display("timer test done");
  endtask : t_timer

  task automatic t_latch();
    logic [7:0] d;
    core.write_reg(9'h18A, 8'hF3);
    rd_chk(9'h00A, 8'h13);
    rd_chk(9'h10A, 8'h13);
    cmp_byte("pc before load", 8'h00, {3'h0, pc_upper});
    @(posedge ref_clk_i) pc_load <= 1'b1;
    @(posedge ref_clk_i) pc_load <= 1'b0;
    @(negedge ref_clk_i);
    cmp_byte("pc after load", 8'h13, {3'h0, pc_upper});
    core.write_then_read(9'h08A, 8'h0C, 9'h10A, d);
    cmp_byte("latch back to back", 8'h0C, d);
    $display("latch test done");
  endtask : t_latch

  task automatic t_serial();
    core.write_reg(9'h093, 8'h5A);
    rd_chk(9'h093, 8'h5A);
    core.write_reg(9'h014, 8'h09);
    rd_chk(9'h093, 8'hFF);
    core.write_reg(9'h093, 8'h0F);
    // the write lands at this edge; look once the register has settled
    @(negedge ref_clk_i);
    cmp_byte("mask out", 8'h0F, ctrl.ssp_mask);
    cmp_byte("addr out", 8'h5A, ctrl.ssp_addr);
    core.write_reg(9'h014, 8'h39);
    rd_chk(9'h093, 8'h0F);
    core.write_reg(9'h014, 8'h08);
    rd_chk(9'h093, 8'h5A);
    $display("serial test done");
  endtask : t_serial

  task automatic t_port_e();
    logic [7:0] d;
    logic [7:0] d_alt;
    core.write_reg(9'h089, 8'h00);
    core.read_reg(9'h089, d, d_alt);
    cmp_byte("dir large", 8'h08, d);
    cmp_byte("dir small", 8'h08, d_alt);
    core.write_reg(9'h089, 8'h07);
    core.read_reg(9'h089, d, d_alt);
    cmp_byte("dir large", 8'h0F, d);
    cmp_byte("dir small", 8'h08, d_alt);
    $display("port e test done");
  endtask : t_port_e

  task automatic t_pulses();
    core.write_reg(9'h019, 8'h66);
    @(negedge ref_clk_i);
    cmp_bit("tx load", 1'b1, tx_load);
    @(negedge ref_clk_i);
    cmp_bit("tx load end", 1'b0, tx_load);
    core.write_reg(9'h013, 8'h77);
    @(negedge ref_clk_i);
    cmp_bit("ssp load", 1'b1, ssp_tx_load);
    // event and clear in one cycle: the flag must survive
    @(posedge ref_clk_i) periph.irq_a_set <= 8'h80;
    core.write_reg(9'h00C, 8'h00);
    periph.irq_a_set <= 8'h00;
    @(posedge ref_clk_i) begin
      periph.uart_rx_valid  <= 1'b1;
      periph.uart_rx_data   <= 8'hC3;
      periph.uart_rx_status <= 3'h5;
    end
    @(posedge ref_clk_i) periph.uart_rx_valid <= 1'b0;
    rd_chk(9'h01A, 8'hC3);
    rd_chk(9'h00C, 8'hA0);
    rd_chk(9'h018, 8'h05);
    rd_chk(9'h019, 8'h66);
    $display("pulse test done");
  endtask : t_pulses

  initial begin
    repeat (4) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    t_reset();
    t_masks();
    t_timer();
    t_latch();
    t_serial();
    t_port_e();
    t_pulses();
    wrap_up();
  end

  // bounded run: a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    fail_count++;
    wrap_up();
  end
endmodule : sfr_bank0_upper_slice_tb
